// ===== hdl/pvic_ctrl.sv
`timescale 1ns/10ps
// What this block does
// - Fifteen sources, two pseudo non-maskable
// - Fixed priority picks among pending requests
// - Vector address steps down by two
// - Latch set by request, cleared on accept
// - Reset clears all pending latches
// - Writes clear latches, never set them
// - Pending latches readable at two addresses
// - Enable register readable, writable, two addresses
// - Master enable at bit 0, reset zero
// - Accept clears master enable; maskable return sets
// - Nonmaskable return restores saved master enable unless already set
// - Trap and watchdog ignore enables, never nest
// - Maskable needs master and own enable
// - External 0 edge ignored when gate low
// - Request held until accepted or cleared
// - Acceptance takes eight machine cycles
// - Push status, PC high, PC low
// - Vector word loads program counter
// - No maskable accept while master enable zero
// - Only PC and status word saved
// - Returns pop three bytes, restore PC, status
// - Requests sampled at instruction final cycle
module pvic_ctrl
  import pvic_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_cycle_en,
  input  wire logic [15:0] i_src_req,
  input  wire logic        i_ext0_gate_bit,
  input  wire logic        i_trap_instruction,
  input  wire logic        i_instr_last,
  input  wire logic        i_enable_all_instruction,
  input  wire logic        i_disable_all_instruction,
  input  wire logic        i_maskable_return,
  input  wire logic        i_nonmaskable_return,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic [7:0]  i_sfr_wdata,
  input  wire logic [15:0] i_pc,
  input  wire logic [7:0]  i_psw,
  input  wire logic [7:0]  i_mem_rdata,
  output logic [7:0]       o_sfr_rdata,
  output logic             o_sfr_hit,
  output logic             o_accept_busy,
  output logic             o_accept_start,
  output logic [3:0]       o_accept_src,
  output logic             o_stack_wr,
  output logic [7:0]       o_stack_wdata,
  output logic             o_sp_dec,
  output logic             o_sp_inc,
  output logic             o_vec_rd,
  output logic [15:0]      o_vec_addr,
  output logic             o_pc_load,
  output logic [15:0]      o_pc_value,
  output logic             o_trap_as_nop,
  output logic             o_master_enable_flag
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    pvic_state_t state;
    logic [15:0] pend;
    logic [15:0] en;
    logic        nmi_active;
    logic        mef_saved;
    logic [3:0]  src;
    logic [3:0]  cnt;
    logic [15:0] pc_hold;
    logic [7:0]  psw_hold;
    logic [7:0]  vec_lo;
    logic [7:0]  rdata;
    logic        hit;
    logic        stack_wr;
    logic [7:0]  stack_wdata;
    logic        sp_dec;
    logic        sp_inc;
    logic        vec_rd;
    logic [15:0] vec_addr;
    logic        pc_load;
    logic [15:0] pc_value;
    logic        trap_nop;
    logic        start;
  } pvic_regs_t;

  pvic_regs_t       state_r;
  pvic_regs_t       state_nxt;
  logic [15:0]      eligible;
  logic             pick_any;
  logic [3:0]       pick_idx;
  logic [15:0]      set_req;
  logic             trap_take;
  logic             take_now;
  logic [3:0]       take_src;
  logic             take_nmi;

  ////////////////////////////////////////////////////////////////////////////
  // Vector word address of a source: two bytes per step below the top
  function automatic logic [15:0] pvic_vector(input logic [3:0] idx);
    pvic_vector = PVIC_VEC_TOP - {11'h000, idx, 1'b0};
  endfunction

  // Address decode shared by reads and writes; a full compare keeps
  // neighbouring special function registers from aliasing into this block
  function automatic logic pvic_is(input logic [7:0] a, input logic [7:0] ref_a);
    pvic_is = (a == ref_a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Eligibility: watchdog ignores enables but is blocked while a
  // pseudo non-maskable service runs; maskable needs master and own flag
  always_comb begin
    eligible = 16'h0000;
    eligible[PVIC_WDT_IDX]  = state_r.pend[PVIC_WDT_IDX] & ~state_r.nmi_active;
    // External 0 has no own flag: its pin gate stands in for one, so a
    // latch set before the gate was closed is not taken either
    eligible[PVIC_EXT0_IDX] = state_r.pend[PVIC_EXT0_IDX]
                              & state_r.en[PVIC_MEF_BIT]
                              & i_ext0_gate_bit;
    // Same bit position for enable and latch keeps this a plain AND
    eligible = eligible | (state_r.pend & state_r.en & PVIC_EF_MASK
                           & {16{state_r.en[PVIC_MEF_BIT]}});
  end

  // Requests only; sources 0 and 1 have no latch, external 0 needs its gate
  always_comb begin
    set_req = i_src_req & PVIC_LATCH_MASK;
    if (!i_ext0_gate_bit) begin
      set_req[PVIC_EXT0_IDX] = 1'b0;
    end
  end

  // Trap is refused as a no-op while a pseudo non-maskable service runs
  assign trap_take = i_trap_instruction & ~state_r.nmi_active;

  ////////////////////////////////////////////////////////////////////////////
  // Take decision, only ever looked at on the last instruction cycle.
  // The trap outranks every latched source, so it is merged in here
  // rather than in the arbiter, which only sees latched requests.
  assign take_now = i_instr_last & (trap_take | pick_any);
  assign take_src = trap_take ? PVIC_SRC_TRAP : pick_idx;
  // Watchdog and trap both open a pseudo non-maskable service
  assign take_nmi = trap_take | (pick_idx == 4'(PVIC_WDT_IDX));

  // Priority pick over the eligible latches
  pvic_arbiter pvic_arbiter_inst (
    .i_eligible (eligible),
    .o_any      (pick_any),
    .o_index    (pick_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  // Later assignments win: a take in the same cycle as an enable write
  // still clears the master flag, and new requests win over clears.
  always_comb begin
    state_nxt             = state_r;
    state_nxt.stack_wr    = 1'b0;
    state_nxt.sp_dec      = 1'b0;
    state_nxt.sp_inc      = 1'b0;
    state_nxt.vec_rd      = 1'b0;
    state_nxt.pc_load     = 1'b0;
    state_nxt.trap_nop    = 1'b0;
    state_nxt.start       = 1'b0;
    state_nxt.hit         = 1'b0;

    // Register reads; reserved latch bits read as zero
    // Read data is held until the next read, so a slow core may take it late
    if (i_sfr_rd) begin
      state_nxt.hit = 1'b1;
      if (pvic_is(i_sfr_addr, PVIC_ADDR_EN_LO)) begin
        state_nxt.rdata = state_r.en[7:0];
      end else if (pvic_is(i_sfr_addr, PVIC_ADDR_EN_HI)) begin
        state_nxt.rdata = state_r.en[15:8];
      end else if (pvic_is(i_sfr_addr, PVIC_ADDR_PEND_LO)) begin
        state_nxt.rdata = state_r.pend[7:0];
      end else if (pvic_is(i_sfr_addr, PVIC_ADDR_PEND_HI)) begin
        state_nxt.rdata = state_r.pend[15:8];
      end else begin
        state_nxt.hit   = 1'b0;
        state_nxt.rdata = 8'h00;
      end
    end

    // Enable writes; a read-modify-write arrives as a plain byte write.
    // Bits 1 to 3 have no flag and read zero.
    // External 0 is gated by its pin gate, not by an enable bit here.
    if (i_sfr_wr && pvic_is(i_sfr_addr, PVIC_ADDR_EN_LO)) begin
      state_nxt.en[7:0] = i_sfr_wdata & PVIC_EF_MASK[7:0] | {7'h00, i_sfr_wdata[0]};
    end
    if (i_sfr_wr && pvic_is(i_sfr_addr, PVIC_ADDR_EN_HI)) begin
      state_nxt.en[15:8] = i_sfr_wdata;
    end
    if (i_enable_all_instruction) begin
      state_nxt.en[PVIC_MEF_BIT] = 1'b1;
    end
    if (i_disable_all_instruction) begin
      state_nxt.en[PVIC_MEF_BIT] = 1'b0;
    end

    // Pending writes can only clear: a zero clears, a one keeps.
    // A read-modify-write here could wipe a request that arrived between
    // the read and the write, which is why only plain loads are allowed.
    // Software is trusted not to clear the watchdog latch.
    if (i_sfr_wr && pvic_is(i_sfr_addr, PVIC_ADDR_PEND_LO)) begin
      state_nxt.pend[7:0] = state_r.pend[7:0] & i_sfr_wdata;
    end
    if (i_sfr_wr && pvic_is(i_sfr_addr, PVIC_ADDR_PEND_HI)) begin
      state_nxt.pend[15:8] = state_r.pend[15:8] & i_sfr_wdata;
    end

    // Returns: PC and status come back from the stack, three pops
    // The core does the three pops; this block only flags them once
    if (i_maskable_return) begin
      state_nxt.en[PVIC_MEF_BIT] = 1'b1;
      state_nxt.nmi_active       = 1'b0;
      state_nxt.sp_inc           = 1'b1;
    end
    if (i_nonmaskable_return) begin
      // Stay set if the service set it, else restore the saved value
      state_nxt.en[PVIC_MEF_BIT] = state_r.en[PVIC_MEF_BIT] | state_r.mef_saved;
      state_nxt.nmi_active       = 1'b0;
      state_nxt.sp_inc           = 1'b1;
    end

    unique case (state_r.state)
      PVIC_ST_IDLE: begin
        // Sampled on the last cycle of the instruction in progress
        if (take_now) begin
          state_nxt.state    = PVIC_ST_ACCEPT;
          state_nxt.start    = 1'b1;
          state_nxt.cnt      = 4'h0;
          state_nxt.src      = take_src;
          // Only PC and status are captured; working registers are the
          // service routine's own business
          state_nxt.pc_hold  = i_pc;
          state_nxt.psw_hold = i_psw;
          state_nxt.vec_addr = pvic_vector(take_src);
          state_nxt.en[PVIC_MEF_BIT] = 1'b0;
          if (take_nmi) begin
            state_nxt.nmi_active = 1'b1;
            state_nxt.mef_saved  = state_r.en[PVIC_MEF_BIT];
          end
          if (!trap_take) begin
            state_nxt.pend[pick_idx] = 1'b0;
          end
        end else if (i_trap_instruction && i_instr_last) begin
          state_nxt.trap_nop = 1'b1;
        end
      end
      PVIC_ST_ACCEPT: begin
        // Step schedule, one step per machine cycle:
        //   step 1..3  push status, PC high, PC low (stack grows down)
        //   step 4     address the low vector byte
        //   step 5     capture low byte, move to the high byte
        //   step 7     load PC from both bytes and go idle
        // Steps 0 and 6 are idle slots that keep the total at eight,
        // matching the core's bus timing for an accepted interrupt.
        if (i_cycle_en) begin
          state_nxt.cnt = state_r.cnt + 4'h1;
          unique case (state_r.cnt)
            PVIC_PUSH_PSW: begin
              state_nxt.stack_wr    = 1'b1;
              state_nxt.sp_dec      = 1'b1;
              state_nxt.stack_wdata = state_r.psw_hold;
            end
            PVIC_PUSH_PCH: begin
              state_nxt.stack_wr    = 1'b1;
              state_nxt.sp_dec      = 1'b1;
              state_nxt.stack_wdata = state_r.pc_hold[15:8];
            end
            PVIC_PUSH_PCL: begin
              state_nxt.stack_wr    = 1'b1;
              state_nxt.sp_dec      = 1'b1;
              state_nxt.stack_wdata = state_r.pc_hold[7:0];
            end
            PVIC_VEC_RD_LO: begin
              state_nxt.vec_rd = 1'b1;
            end
            PVIC_VEC_RD_HI: begin
              state_nxt.vec_lo   = i_mem_rdata;
              state_nxt.vec_rd   = 1'b1;
              state_nxt.vec_addr = state_r.vec_addr + 16'h0001;
            end
            PVIC_ACC_LAST: begin
              state_nxt.pc_value = {i_mem_rdata, state_r.vec_lo};
              state_nxt.pc_load  = 1'b1;
              state_nxt.state    = PVIC_ST_IDLE;
            end
            default: begin
              state_nxt.cnt = state_r.cnt + 4'h1;
            end
          endcase
        end
      end
      default: begin
        state_nxt.state = PVIC_ST_IDLE;
      end
    endcase

    // New requests win over any clear in the same cycle
    state_nxt.pend = state_nxt.pend | set_req;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      // Clearing the whole word also drops any half-done acceptance;
      // the core restarts from its own reset vector anyway
      state_r             <= '0;
      state_r.state       <= PVIC_ST_IDLE;
      state_r.pend        <= PVIC_PEND_RST;
      state_r.en          <= PVIC_EN_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops; busy is decoded from the state register
  assign o_sfr_rdata          = state_r.rdata;
  assign o_sfr_hit            = state_r.hit;
  // Acceptance engine towards the core sequencer
  assign o_accept_busy        = (state_r.state == PVIC_ST_ACCEPT);
  assign o_accept_start       = state_r.start;
  assign o_accept_src         = state_r.src;
  assign o_stack_wr           = state_r.stack_wr;
  assign o_stack_wdata        = state_r.stack_wdata;
  assign o_sp_dec             = state_r.sp_dec;
  assign o_sp_inc             = state_r.sp_inc;
  assign o_vec_rd             = state_r.vec_rd;
  assign o_vec_addr           = state_r.vec_addr;
  assign o_pc_load            = state_r.pc_load;
  assign o_pc_value           = state_r.pc_value;
  assign o_trap_as_nop        = state_r.trap_nop;
  // The flag is the live enable bit, so software and the core agree
  assign o_master_enable_flag = state_r.en[PVIC_MEF_BIT];
endmodule

// ===== hdl/pvic_pkg.sv
package pvic_pkg;
  // Register offsets in the special function area
  localparam logic [7:0]  PVIC_ADDR_EN_LO   = 8'h3A;
  localparam logic [7:0]  PVIC_ADDR_EN_HI   = 8'h3B;
  localparam logic [7:0]  PVIC_ADDR_PEND_LO = 8'h3C;
  localparam logic [7:0]  PVIC_ADDR_PEND_HI = 8'h3D;
  // Reset values and field layout
  localparam logic [15:0] PVIC_PEND_RST     = 16'h0000;
  localparam logic [15:0] PVIC_EN_RST       = 16'h0000;
  localparam int          PVIC_MEF_BIT      = 0;
  localparam int          PVIC_WDT_IDX      = 2;
  localparam int          PVIC_EXT0_IDX     = 3;
  localparam int          PVIC_FIRST_MASK   = 4;
  localparam int          PVIC_NSRC         = 16;
  localparam logic [15:0] PVIC_LATCH_MASK   = 16'hFFFC;
  localparam logic [15:0] PVIC_EF_MASK      = 16'hFFF0;
  // Vector table
  localparam logic [15:0] PVIC_VEC_TOP      = 16'hFFFE;
  localparam logic [3:0]  PVIC_SRC_TRAP     = 4'h1;
  // Acceptance length in machine cycles
  localparam logic [3:0]  PVIC_ACC_CYCLES   = 4'h8;
  localparam logic [3:0]  PVIC_ACC_LAST     = PVIC_ACC_CYCLES - 4'h1;
  localparam logic [3:0]  PVIC_PUSH_PSW     = 4'h1;
  localparam logic [3:0]  PVIC_PUSH_PCH     = 4'h2;
  localparam logic [3:0]  PVIC_PUSH_PCL     = 4'h3;
  localparam logic [3:0]  PVIC_VEC_RD_LO    = 4'h4;
  localparam logic [3:0]  PVIC_VEC_RD_HI    = 4'h5;

  typedef enum logic [1:0] {
    PVIC_ST_IDLE,
    PVIC_ST_ACCEPT
  } pvic_state_t;
endpackage

// ===== hdl/pvic_arbiter.sv
`timescale 1ns/10ps
// Fixed priority pick: lowest index that is eligible wins
module pvic_arbiter
  import pvic_pkg::*;
(
  input  wire logic [15:0] i_eligible,
  output logic             o_any,
  output logic [3:0]       o_index
);
  ////////////////////////////////////////////////////////////////////////////
  // Scan from low priority upward so the highest priority is the last hit
  always_comb begin
    o_any   = 1'b0;
    o_index = 4'h0;
    for (int k = PVIC_NSRC - 1; k >= 0; k--) begin
      if (i_eligible[k]) begin
        o_any   = 1'b1;
        o_index = 4'(k);
      end
    end
  end
endmodule

// ===== tb/pvic_vec_rom.sv
`timescale 1ns/10ps
// Vector table as the core's program memory would answer it
module pvic_vec_rom
  import pvic_pkg::*;
(
  input  wire logic [15:0] i_addr,
  output logic [7:0]       o_data
);
  // Address stays held, so data never goes stale mid-fetch
  assign o_data = i_addr[0] ? 8'hC3 : (i_addr[7:0] ^ 8'h5A);
endmodule

// ===== tb/pvic_ctrl_chk.sv
`timescale 1ns/10ps
// Port-level timing checks for the acceptance engine
module pvic_ctrl_chk
  import pvic_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_reset_n,
  input wire logic        i_sfr_rd,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic        i_maskable_return,
  input wire logic        i_nonmaskable_return,
  input wire logic        o_sfr_hit,
  input wire logic        o_accept_busy,
  input wire logic        o_accept_start,
  input wire logic [3:0]  o_accept_src,
  input wire logic        o_stack_wr,
  input wire logic        o_sp_dec,
  input wire logic        o_sp_inc,
  input wire logic        o_vec_rd,
  input wire logic [15:0] o_vec_addr,
  input wire logic        o_pc_load,
  input wire logic        o_trap_as_nop,
  input wire logic        o_master_enable_flag
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////
  // Acceptance framing; bench keeps cycle enable high throughout
  start_busy_a: assert property (o_accept_start |-> o_accept_busy)
    else $error("start without busy");
  busy_rise_a: assert property ($rose(o_accept_busy) |-> o_accept_start)
    else $error("busy rose without start");
  accept_len_a: assert property (o_accept_start |->
    o_accept_busy[*8] ##1 (o_pc_load && !o_accept_busy))
    else $error("acceptance length wrong");
  stack_dec_a: assert property (o_stack_wr |-> o_sp_dec && o_accept_busy)
    else $error("push without stack decrement");
  vec_addr_a: assert property (o_vec_rd |-> o_vec_addr[15:1] == 15'h7FFF - {11'h0, o_accept_src})
    else $error("vector address wrong");
  mef_clear_a: assert property (o_accept_start |-> !o_master_enable_flag)
    else $error("master enable kept on accept");
  mask_gate_a: assert property (o_accept_start && o_accept_src > 4'h2 |-> $past(o_master_enable_flag))
    else $error("maskable taken while disabled");
  ////////////////////////////////////////////////////////////////
  // Register window and return handling
  sfr_hit_a: assert property (i_sfr_rd |=>
    o_sfr_hit == ($past(i_sfr_addr) inside {[8'h3A:8'h3D]}))
    else $error("register hit wrong");
  ret_inc_a: assert property (i_maskable_return || i_nonmaskable_return |=> o_sp_inc)
    else $error("return without stack increment");
  maskable_return_mef_a: assert property (i_maskable_return |=> o_master_enable_flag)
    else $error("maskable return left master enable low");
  cover property (o_accept_start && o_accept_src == 4'h2);
  cover property (o_trap_as_nop);
  cover property (o_pc_load ##1 o_sp_inc);
endmodule
bind pvic_ctrl pvic_ctrl_chk pvic_ctrl_chk_inst (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
  .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr), .i_maskable_return(i_maskable_return),
  .i_nonmaskable_return(i_nonmaskable_return), .o_sfr_hit(o_sfr_hit),
  .o_accept_busy(o_accept_busy), .o_accept_start(o_accept_start), .o_accept_src(o_accept_src),
  .o_stack_wr(o_stack_wr), .o_sp_dec(o_sp_dec), .o_sp_inc(o_sp_inc), .o_vec_rd(o_vec_rd),
  .o_vec_addr(o_vec_addr), .o_pc_load(o_pc_load), .o_trap_as_nop(o_trap_as_nop),
  .o_master_enable_flag(o_master_enable_flag));

// ===== tb/prioritized_vectored_interrupt_ctrl_test.sv
`timescale 1ns/10ps
module prioritized_vectored_interrupt_ctrl_test
  import pvic_pkg::*;
;
  logic i_ref_clk, i_reset_n, i_cycle_en, i_ext0_gate_bit, i_trap_instruction, i_instr_last;
  logic i_enable_all_instruction, i_disable_all_instruction, i_maskable_return;
  logic i_nonmaskable_return, i_sfr_wr, i_sfr_rd, o_sfr_hit, o_accept_busy, o_accept_start;
  logic o_stack_wr, o_sp_dec, o_sp_inc, o_vec_rd, o_pc_load, o_trap_as_nop, o_master_enable_flag;
  logic [15:0] i_src_req, i_pc, o_vec_addr, o_pc_value;
  logic [7:0]  i_sfr_addr, i_sfr_wdata, i_psw, i_mem_rdata, o_sfr_rdata, o_stack_wdata;
  logic [3:0]  o_accept_src;
  int          fail_count = 0;
  int          checks_done = 0;
  pvic_ctrl pvic_ctrl_inst (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_cycle_en(i_cycle_en),
    .i_src_req(i_src_req), .i_ext0_gate_bit(i_ext0_gate_bit),
    .i_trap_instruction(i_trap_instruction), .i_instr_last(i_instr_last),
    .i_enable_all_instruction(i_enable_all_instruction),
    .i_disable_all_instruction(i_disable_all_instruction),
    .i_maskable_return(i_maskable_return), .i_nonmaskable_return(i_nonmaskable_return),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wdata(i_sfr_wdata), .i_pc(i_pc), .i_psw(i_psw), .i_mem_rdata(i_mem_rdata),
    .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .o_accept_busy(o_accept_busy),
    .o_accept_start(o_accept_start), .o_accept_src(o_accept_src), .o_stack_wr(o_stack_wr),
    .o_stack_wdata(o_stack_wdata), .o_sp_dec(o_sp_dec), .o_sp_inc(o_sp_inc),
    .o_vec_rd(o_vec_rd), .o_vec_addr(o_vec_addr), .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value), .o_trap_as_nop(o_trap_as_nop),
    .o_master_enable_flag(o_master_enable_flag));
  pvic_vec_rom pvic_vec_rom_inst (.i_addr(o_vec_addr), .o_data(i_mem_rdata));
  ////////////////////////////////////////////////////////////////
  // Clock, one machine cycle per clock to keep runs short
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick;
    @(posedge i_ref_clk);
    #1;
  endtask
  // Plain loads only; bench never clears the watchdog latch by write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    tick();
    i_sfr_wr = 1'b0;
    // Let an edge pass so a following strobe is a fresh one
    tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    tick();
    i_sfr_rd = 1'b0;
    chk($sformatf("rd %h", a), {h, o_sfr_rdata}, {h, h ? e : 8'h00});
    chk("hit", o_sfr_hit, h);
    tick();
  endtask
  task automatic pl(input logic [15:0] r);
    i_src_req = r;
    tick();
    i_src_req = 16'h0000;
  endtask
  // Take at instruction end, then judge pushes, vector and flag
  task automatic acc(input logic [3:0] s, input logic tr);
    logic [23:0] st;
    logic [15:0] v;
    int          k;
    int          n;
    st = 24'h000000;
    k = 0;
    n = 0;
    v = 16'hFFFE - {11'h000, s, 1'b0};
    i_trap_instruction = tr;
    i_instr_last = 1'b1;
    tick();
    i_trap_instruction = 1'b0;
    i_instr_last = 1'b0;
    chk("start", {o_accept_start, o_accept_src}, {1'b1, s});
    while (o_pc_load !== 1'b1 && n < 20) begin
      if (o_stack_wr === 1'b1) begin
        st = {st[15:0], o_stack_wdata};
        k++;
      end
      tick();
      n++;
    end
    chk("stack", {8'(k), st}, {8'h03, 8'h5C, 16'h1234});
    chk("pc", {o_pc_load, o_pc_value}, {1'b1, 8'hC3, v[7:0] ^ 8'h5A});
    chk("mef", o_master_enable_flag, 1'b0);
    tick();
  endtask
  task automatic ret(input logic nm, input logic e);
    i_nonmaskable_return = nm;
    i_maskable_return = !nm;
    tick();
    i_nonmaskable_return = 1'b0;
    i_maskable_return = 1'b0;
    chk("ret", {o_sp_inc, o_master_enable_flag}, {1'b1, e});
  endtask
  task automatic held_off(input logic tr, input logic [1:0] e);
    i_trap_instruction = tr;
    i_instr_last = 1'b1;
    tick();
    i_trap_instruction = 1'b0;
    i_instr_last = 1'b0;
    chk("held", {o_trap_as_nop, o_accept_start}, e);
  endtask
  task test_done;
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog: the whole sequence needs about a hundred cycles
  initial begin
    #20000;
    fail_count++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {i_cycle_en, i_ext0_gate_bit, i_trap_instruction, i_instr_last, i_sfr_wr, i_sfr_rd} = 6'h20;
    {i_enable_all_instruction, i_disable_all_instruction} = 2'h0;
    {i_maskable_return, i_nonmaskable_return} = 2'h0;
    {i_src_req, i_pc, i_psw, i_sfr_addr, i_sfr_wdata} = {16'h0000, 16'h1234, 8'h5C, 16'h0000};
    i_reset_n = 1'b0;
    repeat (6) @(posedge i_ref_clk);
    #1;
    i_reset_n = 1'b1;
    foreach (i_psw[i]) if (i < 4) rd(8'h3A + i[7:0], 8'h00, 1'b1);
    wr(8'h3A, 8'hFF);
    wr(8'h3B, 8'hFF);
    rd(8'h3A, 8'hF1, 1'b1);
    rd(8'h3B, 8'hFF, 1'b1);
    rd(8'h40, 8'h00, 1'b0);
    wr(8'h3A, 8'hF0);
    pl(16'hFFFF);
    rd(8'h3C, 8'hF4, 1'b1);
    rd(8'h3D, 8'hFF, 1'b1);
    wr(8'h3C, 8'h04);
    rd(8'h3C, 8'h04, 1'b1);
    wr(8'h3C, 8'hFF);
    rd(8'h3C, 8'h04, 1'b1);
    wr(8'h3D, 8'h00);
    acc(4'h2, 1'b0);
    rd(8'h3C, 8'h00, 1'b1);
    held_off(1'b1, 2'b10);
    ret(1'b1, 1'b0);
    pl(16'h0210);
    held_off(1'b0, 2'b00);
    i_enable_all_instruction = 1'b1;
    tick();
    i_enable_all_instruction = 1'b0;
    rd(8'h3A, 8'hF1, 1'b1);
    acc(4'h4, 1'b0);
    rd(8'h3D, 8'h02, 1'b1);
    ret(1'b0, 1'b1);
    acc(4'h9, 1'b0);
    ret(1'b0, 1'b1);
    i_ext0_gate_bit = 1'b1;
    pl(16'h0008);
    acc(4'h3, 1'b0);
    ret(1'b0, 1'b1);
    acc(4'h1, 1'b1);
    ret(1'b1, 1'b1);
    test_done();
  end
endmodule
